// >>> inc/bpds_guard_if.sv
// dead-time guard connection between sequencer and guard
`timescale 1ns/1ps
`default_nettype none
interface bpds_guard_if;
	logic cmd;
	logic low;
	logic [bpds_pkg::DLY_W-1:0] dead;
	logic drive;
	modport guard (input cmd, input low, input dead, output drive);
	modport ctrl (output cmd, output low, output dead, input drive);
endinterface
`default_nettype wire

// >>> inc/bpds_pkg.sv
// constants and types shared by the bridge drive sequencer
package bpds_pkg;
	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 50;
	localparam int OSC_KHZ = 1000;
	localparam int PERIOD_CYC = (1000000 / CLK_NS) / OSC_KHZ;
	localparam int BLANK_MIN_NS = 50;
	localparam int BLANK_MAX_NS = 300;
	localparam int BLANK_MIN_CYC = (BLANK_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int BLANK_MAX_CYC = BLANK_MAX_NS / CLK_NS;
	localparam int LATCH_SET_NS = 415;
	localparam int LATCH_SET_CYC = LATCH_SET_NS / CLK_NS;
	// ----------------------------------------------------------------
	// widths and soft-start
	// ----------------------------------------------------------------
	localparam int BLANK_W = 4;
	localparam int DLY_W = 8;
	localparam int SS_W = 10;
	localparam int SS_CHARGE_DIV = 16;
	localparam logic [SS_W-1:0] SS_DIS_STEP = 10'h040;
	localparam logic [SS_W-1:0] SS_RESET = 10'h000;
	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {st_lockout, st_off, st_run, st_hiccup, st_latched} bpds_state_t;
endpackage

// >>> logic/bpds_dead_guard.sv
// high-side dead-time guard for one bridge leg
`timescale 1ns/1ps
`default_nettype none
module bpds_dead_guard (
	input wire logic clock_i,
	input wire logic nrst_i,
	bpds_guard_if.guard gif
);
	import bpds_pkg::*;
	logic low_q;
	logic [DLY_W-1:0] cnt;
	logic drive;
	logic next_low_q;
	logic [DLY_W-1:0] next_cnt;
	logic next_drive;
	// ----------------------------------------------------------------
	// hold off after same-leg low side falls
	// ----------------------------------------------------------------
	always_comb begin
		next_low_q = gif.low;
		next_cnt = cnt;
		if (low_q && !gif.low) begin
			next_cnt = gif.dead;
		end else if (cnt != '0) begin
			next_cnt = cnt - 1'b1;
		end
		next_drive = gif.cmd && !gif.low && !(low_q && !gif.low) && (cnt == '0);
	end
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			low_q <= 1'b0;
			cnt <= '0;
			drive <= 1'b0;
		end else begin
			low_q <= next_low_q;
			cnt <= next_cnt;
			drive <= next_drive;
		end
	end
	assign gif.drive = drive;
	a_dead_overlap: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!(drive && gif.low)) else $error("high side on with low side");
	a_dead_wait: assert property (@(posedge clock_i) disable iff (!nrst_i)
		$fell(gif.low) |=> !drive) else $error("high side rose inside dead time");
endmodule
`default_nettype wire

// >>> logic/bpds_seq.sv
// bridge drive sequencer: pwm timing, soft-start and fault handling
`timescale 1ns/1ps
`default_nettype none
module bpds_seq #(
	parameter int PERIOD = bpds_pkg::PERIOD_CYC
) (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic run_i,
	input wire logic fault_latch_input_i,
	input wire logic peak_current_sense_i,
	input wire logic ramp_at_error_i,
	input wire logic supply_above_on_i,
	input wire logic supply_below_off_i,
	input wire logic [bpds_pkg::BLANK_W-1:0] blank_cycles_i,
	input wire logic [bpds_pkg::DLY_W-1:0] res_delay_cycles_i,
	input wire logic [bpds_pkg::DLY_W-1:0] dead_cycles_i,
	output logic high_side_drive_a_o,
	output logic high_side_drive_b_o,
	output logic low_side_drive_a_o,
	output logic low_side_drive_b_o,
	output logic rectifier_gate_a_o,
	output logic rectifier_gate_b_o,
	output logic [bpds_pkg::SS_W-1:0] soft_start_level_o,
	output logic latched_o,
	output logic supply_lockout_o
);
	import bpds_pkg::*;
	localparam logic [7:0] PER_LAST = 8'(PERIOD - 1);
	localparam logic [4:0] SS_DIV_LAST = 5'(SS_CHARGE_DIV - 1);
	localparam logic [BLANK_W-1:0] BL_MIN = BLANK_W'(BLANK_MIN_CYC);
	localparam logic [BLANK_W-1:0] BL_MAX = BLANK_W'(BLANK_MAX_CYC);
	bpds_state_t state, next_state;
	logic supply_ok, next_supply_ok;
	logic fault_latch, next_fault_latch;
	logic [SS_W-1:0] ss, next_ss;
	logic [4:0] ss_div, next_ss_div;
	logic [7:0] per_cnt, next_per_cnt;
	logic phase, next_phase;
	logic dly_act, next_dly_act;
	logic [DLY_W-1:0] dly_cnt, next_dly_cnt;
	logic on, next_on;
	logic [BLANK_W-1:0] bl_cnt, next_bl_cnt;
	logic low_a, low_b, rect_a, rect_b;
	logic next_low_a, next_low_b, next_rect_a, next_rect_b;
	logic run_en, per_end, cmp_gated;
	logic [BLANK_W-1:0] blank_c;
	logic cut_hold, next_cut_hold;
	bpds_guard_if leg_a ();
	bpds_guard_if leg_b ();
	// ----------------------------------------------------------------
	// supply lockout, shutdown latch, state
	// ----------------------------------------------------------------
	always_comb begin
		next_supply_ok = supply_ok;
		if (supply_above_on_i) begin
			next_supply_ok = 1'b1;
		end else if (supply_below_off_i) begin
			next_supply_ok = 1'b0;
		end
		next_fault_latch = fault_latch || fault_latch_input_i;
		next_state = state;
		if (fault_latch || fault_latch_input_i) begin
			next_state = st_latched;
		end else if (!supply_ok) begin
			next_state = st_lockout;
		end else if (!run_i) begin
			next_state = st_off;
		end else begin
			unique case (state)
				st_lockout, st_off: next_state = st_run;
				st_run: next_state = peak_current_sense_i ? st_hiccup : st_run;
				st_hiccup: next_state = (ss == SS_RESET) ? st_run : st_hiccup;
				st_latched: next_state = st_latched;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// soft-start ramp
	// ----------------------------------------------------------------
	always_comb begin
		next_ss_div = (ss_div == SS_DIV_LAST) ? 5'h00 : ss_div + 5'h01;
		next_ss = ss;
		unique case (state)
			st_run: begin
				if (ss_div == SS_DIV_LAST && ss != '1) begin
					next_ss = ss + 1'b1;
				end
			end
			st_hiccup: next_ss = (ss > SS_DIS_STEP) ? ss - SS_DIS_STEP : SS_RESET;
			default: next_ss = SS_RESET;
		endcase
	end
	// ----------------------------------------------------------------
	// period timing and low-side pulse
	// ----------------------------------------------------------------
	assign run_en = (state == st_run) && !peak_current_sense_i;
	assign per_end = (per_cnt == PER_LAST);
	assign blank_c = (blank_cycles_i < BL_MIN) ? BL_MIN : (blank_cycles_i > BL_MAX) ? BL_MAX : blank_cycles_i;
	assign cmp_gated = ramp_at_error_i && (bl_cnt == '0);
	always_comb begin
		next_per_cnt = per_end ? 8'h00 : per_cnt + 8'h01;
		next_phase = per_end ? !phase : phase;
		next_dly_act = dly_act;
		next_dly_cnt = dly_cnt;
		next_on = on;
		next_bl_cnt = (bl_cnt != '0) ? bl_cnt - 1'b1 : bl_cnt;
		if (!run_en || per_end) begin
			next_on = 1'b0;
			next_dly_act = 1'b0;
		end else if (per_cnt == 8'h00) begin
			next_dly_cnt = res_delay_cycles_i;
			next_dly_act = (res_delay_cycles_i != '0);
			next_on = (res_delay_cycles_i == '0);
			next_bl_cnt = blank_c;
		end else if (dly_act) begin
			next_dly_cnt = dly_cnt - 1'b1;
			if (dly_cnt == 8'h01) begin
				next_dly_act = 1'b0;
				next_on = 1'b1;
				next_bl_cnt = blank_c;
			end
		end else if (on && cmp_gated) begin
			next_on = 1'b0;
		end
		next_low_a = next_on && next_phase;
		next_low_b = next_on && !next_phase;
		next_rect_a = run_en && !next_phase;
		next_rect_b = run_en && next_phase;
	end
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= st_lockout;
			supply_ok <= 1'b0;
			fault_latch <= 1'b0;
			ss <= SS_RESET;
			ss_div <= 5'h00;
			per_cnt <= 8'h00;
			phase <= 1'b0;
			dly_act <= 1'b0;
			dly_cnt <= '0;
			on <= 1'b0;
			bl_cnt <= '0;
			low_a <= 1'b0;
			low_b <= 1'b0;
			rect_a <= 1'b0;
			rect_b <= 1'b0;
		end else begin
			state <= next_state;
			supply_ok <= next_supply_ok;
			fault_latch <= next_fault_latch;
			ss <= next_ss;
			ss_div <= next_ss_div;
			per_cnt <= next_per_cnt;
			phase <= next_phase;
			dly_act <= next_dly_act;
			dly_cnt <= next_dly_cnt;
			on <= next_on;
			bl_cnt <= next_bl_cnt;
			low_a <= next_low_a;
			low_b <= next_low_b;
			rect_a <= next_rect_a;
			rect_b <= next_rect_b;
		end
	end
	// ----------------------------------------------------------------
	// high-side guards and outputs
	// ----------------------------------------------------------------
	assign leg_a.cmd = run_en && !phase;
	assign leg_a.low = low_a;
	assign leg_a.dead = dead_cycles_i;
	assign leg_b.cmd = run_en && phase;
	assign leg_b.low = low_b;
	assign leg_b.dead = dead_cycles_i;
	bpds_dead_guard u_guard_a (.clock_i(clock_i), .nrst_i(nrst_i), .gif(leg_a.guard));
	bpds_dead_guard u_guard_b (.clock_i(clock_i), .nrst_i(nrst_i), .gif(leg_b.guard));
	assign high_side_drive_a_o = leg_a.drive;
	assign high_side_drive_b_o = leg_b.drive;
	assign low_side_drive_a_o = low_a;
	assign low_side_drive_b_o = low_b;
	assign rectifier_gate_a_o = rect_a;
	assign rectifier_gate_b_o = rect_b;
	assign soft_start_level_o = ss;
	assign latched_o = fault_latch;
	assign supply_lockout_o = !supply_ok;
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	// pulse cut inside a period stays off until the next period
	always_comb begin
		next_cut_hold = per_end ? 1'b0 : (cut_hold || (on && !next_on));
	end
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cut_hold <= 1'b0;
		end else begin
			cut_hold <= next_cut_hold;
		end
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	a_high_pair_excl: assert property (!(high_side_drive_a_o && high_side_drive_b_o))
		else $error("both high sides on");
	a_low_one_diag: assert property (!(low_a && low_b)) else $error("both low sides on");
	a_phase_toggle: assert property (per_end |=> phase != $past(phase))
		else $error("phase did not toggle at period end");
	a_blank_hold: assert property (on && bl_cnt != '0 && run_en && !per_end |=> on)
		else $error("pulse ended inside blanking");
	a_peak_kill: assert property (peak_current_sense_i |=> !low_a && !low_b
		&& !high_side_drive_a_o && !high_side_drive_b_o) else $error("overcurrent did not end drives");
	a_peak_hiccup: assert property (state == st_run && peak_current_sense_i && run_i && supply_ok
		&& !fault_latch_input_i |=> state == st_hiccup) else $error("overcurrent did not start hiccup");
	a_hold_to_period: assert property (cut_hold |-> !on)
		else $error("pulse restarted inside period");
	a_latch_set: assert property (fault_latch_input_i |=> latched_o && state == st_latched)
		else $error("latch not set");
	a_latch_keep: assert property (latched_o |=> latched_o && state == st_latched)
		else $error("latch cleared without power removal");
	a_off_quiet: assert property (state != st_run && $past(state) != st_run |-> !low_a && !low_b
		&& !high_side_drive_a_o && !high_side_drive_b_o) else $error("drive while disabled");
	a_lockout_ss: assert property (!supply_ok |=> ##1 ss == SS_RESET) else $error("soft-start live in lockout");
	a_end_on_cmp: assert property (on && cmp_gated && !dly_act && per_cnt != 8'h00 |=> !on)
		else $error("pulse missed comparator");
	c_hiccup: cover property (state == st_run ##1 state == st_hiccup);
	c_latched: cover property ($rose(latched_o));
	c_cmp_end: cover property (on && cmp_gated ##1 !on);
	c_full_duty: cover property (on && per_end);
endmodule
`default_nettype wire

// >>> verif/bpds_stage_model.sv
// power stage model: current ramp, overload and shoot-through watch
`timescale 1ns/1ps
`default_nettype none
module bpds_stage_model (
	input wire logic clock_i,
	input wire logic high_a_i,
	input wire logic high_b_i,
	input wire logic low_a_i,
	input wire logic low_b_i,
	input wire logic [7:0] ramp_len_i,
	input wire logic overload_i,
	output logic ramp_at_error_o,
	output logic peak_o,
	output int shoot_o
);
	int cnt = 0;
	initial begin
		ramp_at_error_o = 1'b0;
		peak_o = 1'b0;
		shoot_o = 0;
	end
	// ramp climbs only while a low switch conducts
	always @(negedge clock_i) begin
		cnt = (low_a_i | low_b_i) ? cnt + 1 : 0;
		ramp_at_error_o <= (low_a_i | low_b_i) && cnt >= ramp_len_i;
		if ((high_a_i && low_a_i) || (high_b_i && low_b_i)) begin
			shoot_o <= shoot_o + 1;
		end
	end
	// overload taken on the rising edge, clear of the bench's falling-edge stimulus
	always @(posedge clock_i) begin
		peak_o <= overload_i;
	end
endmodule
`default_nettype wire

// >>> verif/test_bridge_pwm_drive_sequencer.sv
// self-checking bench for the bridge drive sequencer
`timescale 1ns/1ps
`default_nettype none
module test_bridge_pwm_drive_sequencer;
	import bpds_pkg::*;
	logic clock_i = 1'b0, nrst_i = 1'b0, run_i = 1'b0, latch_in = 1'b0;
	logic above_on = 1'b0, below_off = 1'b0, overload = 1'b0;
	logic [BLANK_W-1:0] blank = 4'h2;
	logic [DLY_W-1:0] rdly = 8'h03, ramp_len = 8'hff, dead = 8'h02;
	logic ramp_hit, peak, ha, hb, la, lb, ra, rb, latched, lockout;
	logic [SS_W-1:0] ss;
	int errors = 0, n_tests = 0, shoot;
	int c [6];
	wire [5:0] drv = {ha, hb, la, lb, ra, rb};
	bpds_seq #(.PERIOD(20)) u_dut (.clock_i(clock_i), .nrst_i(nrst_i), .run_i(run_i),
		.fault_latch_input_i(latch_in), .peak_current_sense_i(peak), .ramp_at_error_i(ramp_hit),
		.supply_above_on_i(above_on), .supply_below_off_i(below_off), .blank_cycles_i(blank),
		.res_delay_cycles_i(rdly), .dead_cycles_i(dead), .high_side_drive_a_o(ha),
		.high_side_drive_b_o(hb), .low_side_drive_a_o(la), .low_side_drive_b_o(lb),
		.rectifier_gate_a_o(ra), .rectifier_gate_b_o(rb), .soft_start_level_o(ss),
		.latched_o(latched), .supply_lockout_o(lockout));
	bpds_stage_model u_stage (.clock_i(clock_i), .high_a_i(ha), .high_b_i(hb), .low_a_i(la),
		.low_b_i(lb), .ramp_len_i(ramp_len), .overload_i(overload), .ramp_at_error_o(ramp_hit),
		.peak_o(peak), .shoot_o(shoot));
	initial begin
		forever #25 clock_i = ~clock_i;
	end
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	// count high cycles of every drive output over a window
	task win(input int n);
		foreach (c[i]) c[i] = 0;
		repeat (n) begin
			@(negedge clock_i);
			foreach (c[i]) c[i] += (drv[i] === 1'b1);
		end
	endtask
	task pulse_w(output int w);
		int k;
		w = 0;
		for (k = 0; k < 100 && (la | lb) !== 1'b0; k++) @(negedge clock_i);
		for (k = 0; k < 100 && (la | lb) !== 1'b1; k++) @(negedge clock_i);
		while ((la | lb) === 1'b1 && w < 100) begin
			w++;
			@(negedge clock_i);
		end
	endtask
	task t_start;
		win(40);
		chk("lockout before supply", lockout, 1);
		chk("drives before supply", c.sum(), 0);
		above_on = 1'b1;
		run_i = 1'b1;
		cyc(45);
		chk("lockout off", lockout, 0);
		win(40);
		chk("rect a half", c[1], 20);
		chk("rect b half", c[0], 20);
		chk("high a vs b", c[5], c[4]);
		chk("high a on", c[5] > 0, 1);
		chk("low a vs b", c[3], c[2]);
		chk("soft start up", ss != 0, 1);
		$display("test start done");
	endtask
	task t_timing;
		int w2, w6, w3, w7, wc, w0;
		ramp_len = 8'h00;
		pulse_w(w2);
		pulse_w(w2);
		blank = 4'h6;
		pulse_w(w6);
		pulse_w(w6);
		chk("blank width step", w6 - w2, 4);
		blank = 4'hf;
		pulse_w(wc);
		pulse_w(wc);
		chk("blank clamp", wc, w6);
		blank = 4'h2;
		ramp_len = 8'hff;
		pulse_w(w3);
		pulse_w(w3);
		chk("ramp cuts pulse", w6 < w3, 1);
		rdly = 8'h07;
		pulse_w(w7);
		pulse_w(w7);
		chk("delay moves lead", w3 - w7, 4);
		rdly = 8'h00;
		pulse_w(w0);
		pulse_w(w0);
		chk("zero delay", w0 - w3, 3);
		rdly = 8'h03;
		$display("test timing done");
	endtask
	task t_dead;
		int g, k;
		dead = 8'h05;
		g = 0;
		cyc(40);
		for (k = 0; k < 100 && la !== 1'b1; k++) @(negedge clock_i);
		for (k = 0; k < 100 && la !== 1'b0; k++) @(negedge clock_i);
		while (ha !== 1'b1 && g < 100) begin
			g++;
			@(negedge clock_i);
		end
		chk("dead time gap", g, 7);
		dead = 8'h02;
		$display("test dead time done");
	endtask
	task t_oc;
		overload = 1'b1;
		cyc(3);
		chk("oc lows off", {la, lb}, 0);
		chk("oc soft start", ss, 0);
		win(40);
		chk("hiccup lows", c[3] + c[2], 0);
		chk("hiccup highs", c[5] + c[4], 0);
		overload = 1'b0;
		cyc(200);
		win(40);
		chk("resumed", c[3] > 0, 1);
		chk("soft start again", ss != 0, 1);
		$display("test overcurrent done");
	endtask
	task t_run;
		run_i = 1'b0;
		cyc(3);
		win(40);
		chk("run low drives", c.sum(), 0);
		chk("run low soft start", ss, 0);
		run_i = 1'b1;
		cyc(100);
		chk("restart", ss != 0, 1);
		$display("test run control done");
	endtask
	task t_supply_lockout;
		above_on = 1'b0;
		below_off = 1'b1;
		cyc(3);
		win(40);
		chk("supply_lockout lockout", lockout, 1);
		chk("supply_lockout drives", c.sum(), 0);
		below_off = 1'b0;
		cyc(20);
		chk("hysteresis hold", lockout, 1);
		above_on = 1'b1;
		cyc(5);
		chk("supply_lockout release", lockout, 0);
		$display("test lockout done");
	endtask
	task t_latch;
		latch_in = 1'b1;
		cyc(1);
		latch_in = 1'b0;
		cyc(LATCH_SET_CYC);
		chk("latch set", latched, 1);
		chk("latch soft start", ss, 0);
		run_i = 1'b0;
		cyc(5);
		run_i = 1'b1;
		win(40);
		chk("latch holds", latched, 1);
		chk("latched drives", c.sum(), 0);
		nrst_i = 1'b0;
		cyc(3);
		nrst_i = 1'b1;
		chk("latch cleared", latched, 0);
		cyc(100);
		chk("soft start after power", ss != 0, 1);
		$display("test latch done");
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		cyc(3);
		nrst_i = 1'b1;
		t_start();
		t_timing();
		t_dead();
		t_oc();
		t_run();
		t_supply_lockout();
		t_latch();
		chk("no shoot through", shoot, 0);
		close_out();
	end
	initial begin
		repeat (20000) @(posedge clock_i);
		errors++;
		close_out();
	end
endmodule
`default_nettype wire
